//--- src/mwm_pkg.sv
`default_nettype none
package mwm_pkg;

    // ==========================================
    // Units and widths
    // ==========================================
    // Deviation in 0.01 rev, temperature in deg C, voltage in 0.1 V,
    // speed in r/min, overload time in 0.1 s, travel in pulses.
    localparam int DEV_W   = 16;
    localparam int TEMP_W  = 8;
    localparam int VOLT_W  = 10;
    localparam int SPD_W   = 13;
    localparam int OVLT_W  = 9;
    localparam int POS_W   = 40;
    localparam int ANG_W   = 16;

    // ==========================================
    // Defaults and limits
    // ==========================================
    localparam logic [DEV_W-1:0]  DEV_ON_DEF   = 16'h012C;  // 3.00 rev
    localparam logic [DEV_W-1:0]  DEV_ON_MIN   = 16'h0001;  // 0.01 rev
    localparam logic [DEV_W-1:0]  DEV_ON_MAX   = 16'h7530;  // 300.00 rev
    localparam logic [DEV_W-1:0]  DEV_OFF_DEF  = 16'h2710;  // 100.00 rev
    localparam logic [TEMP_W-1:0] TEMP_MIN     = 8'h28;     // 40 C
    localparam logic [TEMP_W-1:0] TEMP_DEF     = 8'h55;     // 85 C
    localparam logic [VOLT_W-1:0] OVV_MIN      = 10'h096;   // 15.0 V
    localparam logic [VOLT_W-1:0] OVV_DEF      = 10'h276;   // 63.0 V
    localparam logic [VOLT_W-1:0] UNV_DEF      = 10'h0B4;   // 18.0 V
    localparam logic [OVLT_W-1:0] OVLT_MIN     = 9'h001;    // 0.1 s
    localparam logic [OVLT_W-1:0] OVLT_MAX     = 9'h12C;    // 30.0 s
    localparam logic [OVLT_W-1:0] OVLT_DEF     = 9'h032;    // 5.0 s
    localparam logic [SPD_W-1:0]  SPD_MIN      = 13'h0001;  // 1 r/min
    localparam logic [SPD_W-1:0]  SPD_MAX      = 13'h1388;  // 5000 r/min
    localparam logic [SPD_W-1:0]  SPD_DEF      = 13'h1194;  // 4500 r/min
    localparam logic [POS_W-1:0]  TRAVEL_LIM   = 40'h0080000000; // 2,147,483,648
    localparam logic [ANG_W-1:0]  OVL_ANG      = 16'h00B4;  // 1.80 deg in 0.01 deg

    // ==========================================
    // Timing
    // ==========================================
    localparam int CLK_MHZ       = 100;
    localparam int TICK_MS       = 100;  // One overload time step, 0.1 s
    localparam int TICK_CYC_DEF  = TICK_MS * 1000 * CLK_MHZ;
    localparam int TICK_W        = 24;

    // ==========================================
    // Carriers
    // ==========================================
    typedef struct packed {
        logic [DEV_W-1:0]  dev_on_lim;
        logic [DEV_W-1:0]  dev_off_lim;
        logic              auto_return_en;
        logic [TEMP_W-1:0] temp_lim;
        logic [VOLT_W-1:0] ovv_lim;
        logic [VOLT_W-1:0] unv_lim;
        logic [OVLT_W-1:0] ovl_time;
        logic [SPD_W-1:0]  spd_lim;
        logic              travel_chk_en;
        logic              current_ctrl_mode;
    } mwm_cfg_t;

    typedef struct packed {
        logic              energized;
        logic [DEV_W-1:0]  pos_dev;     // Magnitude, 0.01 rev
        logic [ANG_W-1:0]  pos_dev_ang; // Magnitude, 0.01 deg
        logic              cur_at_limit;
        logic [TEMP_W-1:0] temp;
        logic [VOLT_W-1:0] volt;
        logic [SPD_W-1:0]  speed;
        logic [POS_W-1:0]  travel;      // Magnitude from electrical home
        logic              res_sel;
        logic              gear_res_bad;
    } mwm_meas_t;

    typedef struct packed {
        logic dev_on;
        logic dev_off;
        logic overheat;
        logic overvolt;
        logic undervolt;
        logic overload;
        logic overspeed;
        logic op_data;
        logic gear;
    } mwm_warn_t;

    typedef enum logic [1:0] {
        MWM_OVL_IDLE = 2'b01,
        MWM_OVL_TIME = 2'b10
    } mwm_ovl_st_t;

endpackage : mwm_pkg

`default_nettype wire

//--- src/mwm_ovl_timer.sv
`timescale 1ns/1ps
`default_nettype none

module mwm_ovl_timer
    import mwm_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
)(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              load_high,
    input  wire logic [OVLT_W-1:0] limit,
    output var  logic              expired
);

    // ==========================================
    // Overload duration timer
    // ==========================================
    mwm_ovl_st_t       st_r,    st_nxt;
    logic [TICK_W-1:0] cyc_r,   cyc_nxt;
    logic [OVLT_W-1:0] steps_r, steps_nxt;
    logic              exp_r,   exp_nxt;
    logic [OVLT_W-1:0] lim_eff;

    // Clamp to the settable range so a zero limit cannot fire instantly
    always_comb
    begin
        if (limit < OVLT_MIN)
            lim_eff = OVLT_MIN;
        else if (limit > OVLT_MAX)
            lim_eff = OVLT_MAX;
        else
            lim_eff = limit;
    end

    always_comb
    begin
        st_nxt    = st_r;
        cyc_nxt   = cyc_r;
        steps_nxt = steps_r;
        exp_nxt   = 1'b0;
        case (st_r)
            MWM_OVL_IDLE:
            begin
                cyc_nxt   = '0;
                steps_nxt = '0;
                if (load_high)
                    st_nxt = MWM_OVL_TIME;
            end
            MWM_OVL_TIME:
            begin
                if (!load_high)
                begin
                    st_nxt    = MWM_OVL_IDLE;
                    cyc_nxt   = '0;
                    steps_nxt = '0;
                end
                else if (steps_r >= lim_eff)
                    exp_nxt = 1'b1;
                else if (cyc_r == TICK_W'(TICK_CYC - 1))
                begin
                    cyc_nxt   = '0;
                    steps_nxt = steps_r + OVLT_W'(1);
                    exp_nxt   = (steps_r + OVLT_W'(1)) >= lim_eff;
                end
                else
                    cyc_nxt = cyc_r + TICK_W'(1);
            end
            default:
            begin
                st_nxt    = MWM_OVL_IDLE;
                cyc_nxt   = '0;
                steps_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r    <= MWM_OVL_IDLE;
            cyc_r   <= '0;
            steps_r <= '0;
            exp_r   <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            cyc_r   <= cyc_nxt;
            steps_r <= steps_nxt;
            exp_r   <= exp_nxt;
        end
    end

    assign expired = exp_r;

endmodule // mwm_ovl_timer

`default_nettype wire

//--- src/mwm_monitor.sv
// What this block does
// - Energized deviation over on-threshold warns
// - De-energized deviation over off-threshold warns, auto-return only
// - Temperature above limit raises overheat warning
// - Voltage above limit raises overvoltage warning
// - Voltage below lower limit raises undervoltage
// - Overload persisting configured time raises warning
// - Speed above limit raises overspeed warning
// - Resolution-select change while energized warns
// - Travel beyond control range warns when enabled
// - Gear resolution out of range warns
// - Any active warning asserts warning output
// - Overload: deviation 1.8 deg, or current limit instead in current-control mode
`timescale 1ns/1ps
`default_nettype none

module mwm_monitor
    import mwm_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
)(
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire mwm_pkg::mwm_cfg_t  cfg,
    input  wire mwm_pkg::mwm_meas_t meas,
    output var  mwm_pkg::mwm_warn_t warn,
    output var  logic               warning_output
);

    // ==========================================
    // Threshold clamping
    // ==========================================
    logic [DEV_W-1:0]  dev_on_eff;
    logic [TEMP_W-1:0] temp_eff;
    logic [VOLT_W-1:0] ovv_eff;
    logic [SPD_W-1:0]  spd_eff;

    // Out-of-range settings are pinned to the nearest legal value;
    // off-deviation and undervoltage have no stated range and pass as set
    always_comb
    begin
        if (cfg.dev_on_lim < DEV_ON_MIN)
            dev_on_eff = DEV_ON_MIN;
        else if (cfg.dev_on_lim > DEV_ON_MAX)
            dev_on_eff = DEV_ON_MAX;
        else
            dev_on_eff = cfg.dev_on_lim;
    end

    always_comb
    begin
        if (cfg.temp_lim < TEMP_MIN)
            temp_eff = TEMP_MIN;
        else if (cfg.temp_lim > TEMP_DEF)
            temp_eff = TEMP_DEF;
        else
            temp_eff = cfg.temp_lim;
    end

    always_comb
    begin
        if (cfg.ovv_lim < OVV_MIN)
            ovv_eff = OVV_MIN;
        else if (cfg.ovv_lim > OVV_DEF)
            ovv_eff = OVV_DEF;
        else
            ovv_eff = cfg.ovv_lim;
    end

    always_comb
    begin
        if (cfg.spd_lim < SPD_MIN)
            spd_eff = SPD_MIN;
        else if (cfg.spd_lim > SPD_MAX)
            spd_eff = SPD_MAX;
        else
            spd_eff = cfg.spd_lim;
    end

    // ==========================================
    // Overload detection
    // ==========================================
    logic load_high;
    logic ovl_expired;

    always_comb
    begin
        if (cfg.current_ctrl_mode)
            load_high = meas.cur_at_limit;
        else
            load_high = (meas.pos_dev_ang >= OVL_ANG);
    end

    // Any lapse of the load restarts the timer, so bursts shorter
    // than the set time never warn
    mwm_ovl_timer #(
        .TICK_CYC (TICK_CYC)
    ) u_ovl_timer (
        .clk       (clk),
        .nrst      (nrst),
        .load_high (load_high),
        .limit     (cfg.ovl_time),
        .expired   (ovl_expired)
    );

    // ==========================================
    // Resolution-select change tracking
    // ==========================================
    // The change flag holds while energized and clears at current off,
    // otherwise a single glitch would leave no visible warning.
    // First sample after reset only loads the old level, so a select
    // held high through reset is not taken for a change.
    logic res_prev_r, res_prev_nxt;
    logic res_seen_r, res_seen_nxt;
    logic res_chg_r,  res_chg_nxt;

    always_comb
    begin
        res_prev_nxt = meas.res_sel;
        res_seen_nxt = 1'b1;
        res_chg_nxt  = res_chg_r;
        if (!meas.energized)
            res_chg_nxt = 1'b0;
        else if (res_seen_r && (meas.res_sel != res_prev_r))
            res_chg_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            res_prev_r <= 1'b0;
            res_seen_r <= 1'b0;
            res_chg_r  <= 1'b0;
        end
        else
        begin
            res_prev_r <= res_prev_nxt;
            res_seen_r <= res_seen_nxt;
            res_chg_r  <= res_chg_nxt;
        end
    end

    // ==========================================
    // Threshold comparators
    // ==========================================
    logic dev_on_hit;
    logic dev_off_hit;
    logic heat_hit;
    logic ovv_hit;
    logic unv_hit;
    logic spd_hit;
    logic travel_hit;

    // Strict compares: a reading equal to its limit is still legal
    // Travel is a magnitude, so one compare covers both directions
    always_comb
    begin
        dev_on_hit  = meas.energized && (meas.pos_dev > dev_on_eff);
        dev_off_hit = !meas.energized && cfg.auto_return_en
                      && (meas.pos_dev > cfg.dev_off_lim);
        heat_hit    = meas.temp > temp_eff;
        ovv_hit     = meas.volt > ovv_eff;
        unv_hit     = meas.volt < cfg.unv_lim;
        spd_hit     = meas.speed > spd_eff;
        travel_hit  = cfg.travel_chk_en && (meas.travel > TRAVEL_LIM);
    end

    // ==========================================
    // Warning evaluation
    // ==========================================
    mwm_warn_t warn_r, warn_nxt;

    // Recomputed every cycle, so each bit but the held select-change part of op_data drops with its cause
    always_comb
    begin
        warn_nxt.dev_on    = dev_on_hit;
        warn_nxt.dev_off   = dev_off_hit;
        warn_nxt.overheat  = heat_hit;
        warn_nxt.overvolt  = ovv_hit;
        warn_nxt.undervolt = unv_hit;
        warn_nxt.overload  = ovl_expired;
        warn_nxt.overspeed = spd_hit;
        warn_nxt.op_data   = res_chg_nxt || travel_hit;
        // Gear range is judged upstream; only registered here
        warn_nxt.gear      = meas.gear_res_bad;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            warn_r <= '0;
        else
            warn_r <= warn_nxt;
    end

    // ==========================================
    // Warning output
    // ==========================================
    logic out_r, out_nxt;

    // Built from the next warning set, not the registered one, so the
    // output rises in the same cycle as the bit that causes it
    always_comb
    begin
        out_nxt = |warn_nxt;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            out_r <= 1'b0;
        else
            out_r <= out_nxt;
    end

    assign warn           = warn_r;
    assign warning_output = out_r;

endmodule // mwm_monitor

`default_nettype wire

//--- verif/mwm_monitor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mwm_monitor_assertions
    import mwm_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF
)(
    input wire logic               clk,
    input wire logic               nrst,
    input wire mwm_pkg::mwm_cfg_t  cfg,
    input wire mwm_pkg::mwm_meas_t meas,
    input wire mwm_pkg::mwm_warn_t warn,
    input wire logic               warning_output
);
    // ==========================================
    // Checks
    // ==========================================
    logic              ld;
    logic [DEV_W-1:0]  don_x;
    logic [TEMP_W-1:0] tmp_x;
    logic [VOLT_W-1:0] ovv_x;
    logic [SPD_W-1:0]  spd_x;
    assign ld = cfg.current_ctrl_mode ? meas.cur_at_limit : meas.pos_dev_ang >= OVL_ANG;
    // Settings outside their legal range act as the nearest bound
    assign don_x = (cfg.dev_on_lim < DEV_ON_MIN) ? DEV_ON_MIN
                 : (cfg.dev_on_lim > DEV_ON_MAX) ? DEV_ON_MAX : cfg.dev_on_lim;
    assign tmp_x = (cfg.temp_lim < TEMP_MIN) ? TEMP_MIN
                 : (cfg.temp_lim > TEMP_DEF) ? TEMP_DEF : cfg.temp_lim;
    assign ovv_x = (cfg.ovv_lim < OVV_MIN) ? OVV_MIN
                 : (cfg.ovv_lim > OVV_DEF) ? OVV_DEF : cfg.ovv_lim;
    assign spd_x = (cfg.spd_lim < SPD_MIN) ? SPD_MIN
                 : (cfg.spd_lim > SPD_MAX) ? SPD_MAX : cfg.spd_lim;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_DEV_ON: assert property (1 |=> warn.dev_on ==
        $past(meas.energized && meas.pos_dev > don_x)) else $error("dev_on");
    AST_DEV_OFF: assert property (1 |=> warn.dev_off == $past(!meas.energized &&
        cfg.auto_return_en && meas.pos_dev > cfg.dev_off_lim)) else $error("dev_off");
    AST_HEAT: assert property (1 |=> warn.overheat ==
        $past(meas.temp > tmp_x)) else $error("overheat");
    AST_OVV: assert property (1 |=> warn.overvolt ==
        $past(meas.volt > ovv_x)) else $error("overvolt");
    AST_UNV: assert property (1 |=> warn.undervolt ==
        $past(meas.volt < cfg.unv_lim)) else $error("undervolt");
    AST_OVL_EARLY: assert property ($rose(ld) && !warn.overload |=>
        !warn.overload[*4]) else $error("overload early");
    AST_OVL_CLR: assert property ((!ld)[*4] |-> !warn.overload)
        else $error("overload stuck");
    AST_SPD: assert property (1 |=> warn.overspeed ==
        $past(meas.speed > spd_x)) else $error("overspeed");
    AST_RES: assert property ($past(nrst) && meas.energized && $changed(meas.res_sel) |=>
        warn.op_data) else $error("res change");
    AST_TRAVEL: assert property (cfg.travel_chk_en && meas.travel > TRAVEL_LIM |=>
        warn.op_data) else $error("travel");
    AST_WNG: assert property (warning_output == (|warn))
        else $error("warning output");
    AST_GEAR: assert property (1 |=> warn.gear == $past(meas.gear_res_bad))
        else $error("gear");
    AST_OPD_CLR: assert property (!meas.energized && !(cfg.travel_chk_en &&
        meas.travel > TRAVEL_LIM) |=> !warn.op_data) else $error("op_data stuck");
    COV_OVL: cover property (warn.overload);
    COV_OFF: cover property (warn.dev_off);
    COV_CLR: cover property ($fell(warning_output));
    COV_RES: cover property (meas.energized && $changed(meas.res_sel));
endmodule // mwm_monitor_assertions

bind mwm_monitor mwm_monitor_assertions #(.TICK_CYC(TICK_CYC)) u_chk (.clk(clk),
    .nrst(nrst), .cfg(cfg), .meas(meas), .warn(warn), .warning_output(warning_output));
`default_nettype wire

//--- verif/mwm_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mwm_host_model (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       warning_output,
    output var  logic [7:0] rises
);
    // ==========================================
    // Host counts warning episodes
    // ==========================================
    logic seen_r;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            seen_r <= 1'b0;
            rises  <= 8'h00;
        end
        else
        begin
            seen_r <= warning_output;
            rises  <= rises + {7'h00, warning_output & ~seen_r};
        end
    end
endmodule // mwm_host_model
`default_nettype wire

//--- verif/motor_warning_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none
module motor_warning_monitor_test;
    import mwm_pkg::*;
    // ==========================================
    // Setup
    // ==========================================
    localparam mwm_cfg_t CI = '{DEV_ON_DEF, DEV_OFF_DEF, 1'b0, TEMP_DEF, OVV_DEF,
        UNV_DEF, 9'h002, SPD_DEF, 1'b0, 1'b0};
    localparam mwm_meas_t VI = '{1'b0, 16'h0000, 16'h0000, 1'b0, 8'h19, 10'h0F0,
        13'h0000, 40'h0000000000, 1'b0, 1'b0};
    logic       clk  = 1'b0;
    logic       nrst = 1'b0;
    mwm_cfg_t   cfg  = CI;
    mwm_cfg_t   c    = CI;
    mwm_meas_t  m    = VI;
    mwm_meas_t  v    = VI;
    mwm_warn_t  warn;
    logic       wo;
    logic [7:0] rises;
    int         num_errors = 0;
    int         checked = 0;
    always #5 clk = ~clk;
    // Short tick keeps overload runs to a few cycles
    mwm_monitor #(.TICK_CYC(4)) dut (.clk(clk), .nrst(nrst), .cfg(cfg), .meas(m),
        .warn(warn), .warning_output(wo));
    mwm_host_model host (.clk(clk), .nrst(nrst), .warning_output(wo), .rises(rises));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] x);
        checked++;
        if (g !== x)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic cw(input logic [8:0] e);
        chk({6'h00, warn, wo}, {6'h00, e, |e});
    endtask
    task automatic ap(input int n, input logic [8:0] e);
        @(posedge clk);
        cfg <= c;
        m   <= v;
        tick(n);
        cw(e);
    endtask
    task automatic idle(input int n);
        c = CI;
        v = VI;
        ap(n, 9'h000);
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_temp_volt;
        v.temp = c.temp_lim;
        ap(1, 9'h000);
        v.temp = c.temp_lim + 8'h01;
        ap(1, 9'h040);
        v = VI;
        v.volt = OVV_DEF + 10'h001;
        ap(1, 9'h020);
        v.volt = UNV_DEF;
        ap(1, 9'h000);
        v.volt = UNV_DEF - 10'h001;
        ap(1, 9'h010);
        c.ovv_lim = OVV_MIN;
        v.volt = OVV_MIN + 10'h001;
        ap(1, 9'h030);
        idle(1);
    endtask
    task automatic t_speed_gear;
        v.speed = SPD_DEF + 13'h0001;
        ap(1, 9'h004);
        c.spd_lim = SPD_MAX;
        v.speed = SPD_MAX;
        v.gear_res_bad = 1'b1;
        ap(1, 9'h001);
        idle(1);
    endtask
    task automatic t_dev;
        v.energized = 1'b1;
        v.pos_dev = c.dev_on_lim;
        ap(1, 9'h000);
        v.pos_dev = c.dev_on_lim + 16'h0001;
        ap(1, 9'h100);
        v.energized = 1'b0;
        v.pos_dev = DEV_OFF_DEF + 16'h0001;
        ap(1, 9'h000);
        c.auto_return_en = 1'b1;
        ap(1, 9'h080);
        v.pos_dev = DEV_OFF_DEF;
        ap(1, 9'h000);
        idle(1);
    endtask
    task automatic t_ovl;
        v.pos_dev_ang = OVL_ANG - 16'h0001;
        ap(15, 9'h000);
        v.pos_dev_ang = OVL_ANG;
        ap(6, 9'h000);
        tick(8);
        cw(9'h008);
        idle(3);
        c.current_ctrl_mode = 1'b1;
        v.pos_dev_ang = OVL_ANG;
        ap(15, 9'h000);
        v.cur_at_limit = 1'b1;
        ap(14, 9'h008);
        idle(3);
    endtask
    task automatic t_op;
        v.energized = 1'b1;
        ap(1, 9'h000);
        v.res_sel = 1'b1;
        ap(1, 9'h002);
        v.res_sel = 1'b0;
        ap(1, 9'h002);
        v.energized = 1'b0;
        ap(2, 9'h000);
        v.res_sel = 1'b1;
        v.travel = TRAVEL_LIM + 40'h0000000001;
        ap(1, 9'h000);
        c.travel_chk_en = 1'b1;
        ap(1, 9'h002);
        v.travel = TRAVEL_LIM;
        ap(1, 9'h000);
        idle(1);
    endtask
    task automatic t_clamp;
        c.temp_lim = 8'h00;
        c.spd_lim = 13'h1FFF;
        c.dev_on_lim = 16'h0000;
        v.temp = TEMP_MIN + 8'h01;
        v.speed = SPD_MAX;
        ap(1, 9'h040);
        v.speed = SPD_MAX + 13'h0001;
        ap(1, 9'h044);
        v.energized = 1'b1;
        v.pos_dev = DEV_ON_MIN;
        ap(1, 9'h044);
        v.pos_dev = DEV_ON_MIN + 16'h0001;
        ap(1, 9'h144);
        idle(1);
    endtask
    task automatic test_done;
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        tick(2);
        t_temp_volt();
        t_speed_gear();
        t_dev();
        t_ovl();
        t_op();
        t_clamp();
        // Ten separate warning episodes across all scenarios
        chk({8'h00, rises}, 16'h000A);
        test_done();
    end
    initial
    begin
        #20000;
        num_errors++;
        test_done();
    end
endmodule // motor_warning_monitor_test
`default_nettype wire
